/* File: onchip_eeprom_two_wire_slave.sv */
// Top of the on-chip serial data memory with its register slave
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Sixteen byte memory, serial access only
// - Data bit six, clock bit seven
// - Serial lines stay internal, no pins
// - Lines always outputs, direction ignored
// - Data line open drain with pull-up
// - Clock push-pull; both bits one after reset
// - Data changes only while clock low
// - Data fall, clock high: start
// - Data rise, clock high: stop
// - One stable bit per clock pulse
// - Any byte count between start, stop
// - Receiver acknowledges every byte
// - Acknowledge holds data low whole high
// - No acknowledge during programming cycle
// - Write cycle busy up to 4 ms
// - Slave releases data on withheld acknowledge
// - Control byte: code, three ignored, direction
// - Only low four address bits used
// - Pointer advances after every byte read
module onchip_eeprom_two_wire_slave
#(
    parameter int unsigned write_cycle_cycles =
        eeprom_pkg::WRITE_CYCLE_CYCLES
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // AXI4-Lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address and data
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    // ==========================================================
    // Declarations
    port_bits_if pb ();

    logic [7:0] mem [eeprom_pkg::MEM_DEPTH];
    eeprom_pkg::phase_t phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic pull_low;
    logic read_dir;
    logic [eeprom_pkg::MEM_AW-1:0] addr_ptr;
    logic [7:0] wbuf;
    logic wbuf_valid;
    logic [eeprom_pkg::BUSY_W-1:0] busy_cnt;
    logic sda_q;
    logic scl_q;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic commit;
    logic ctrl_match;
    logic [7:0] rd_byte;

    // ==========================================================
    // Register slave
    axi_port_regs regs_i
    (
        .ref_clk (ref_clk),
        .rst (rst),
        .awaddr (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata (wdata),
        .wstrb (wstrb),
        .wvalid (wvalid),
        .wready (wready),
        .bresp (bresp),
        .bvalid (bvalid),
        .bready (bready),
        .araddr (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata (rdata),
        .rresp (rresp),
        .rvalid (rvalid),
        .rready (rready),
        .pb (pb)
    );

    // ==========================================================
    // Internal line levels
    // Both lines live only between port bits and memory, no pad.
    // Clock is driven straight from its bit; data is wired-AND of
    // the port bit and the memory pull-down, pull-up supplying one.
    assign pb.scl_level = pb.scl_out;
    assign pb.sda_level = pb.sda_out & ~pull_low;
    assign pb.busy = (busy_cnt != '0);

    // Levels are on our own clock, so no synchroniser is needed
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sda_q <= eeprom_pkg::SDA_RESET;
            scl_q <= eeprom_pkg::SCL_RESET;
        end
        else
        begin
            sda_q <= pb.sda_level;
            scl_q <= pb.scl_level;
        end
    end

    // Bus conditions from consecutive samples
    assign scl_rise = pb.scl_level & ~scl_q;
    assign scl_fall = ~pb.scl_level & scl_q;
    // Data edges with clock held high are framing only
    assign start_cond = pb.scl_level & scl_q & sda_q &
                        ~pb.sda_level;
    assign stop_cond = pb.scl_level & scl_q & ~sda_q &
                       pb.sda_level;

    // Control byte: code in top nibble, three bits ignored
    assign ctrl_match = (shift[7:4] == eeprom_pkg::DEVICE_CODE);
    // Byte write commits only on a whole buffered byte at stop;
    // a stop mid-byte or before any data aborts with no write.
    assign commit = stop_cond && (phase == eeprom_pkg::ph_wdata) &&
                    wbuf_valid && (bit_cnt == 4'h0);
    assign rd_byte = mem[addr_ptr];

    // ==========================================================
    // Serial protocol engine
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            phase <= eeprom_pkg::ph_idle;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            pull_low <= 1'b0;
            read_dir <= 1'b0;
            addr_ptr <= '0;
            wbuf <= 8'h00;
            wbuf_valid <= 1'b0;
        end
        else if (start_cond)
        begin
            // A start, repeated or not, always reopens addressing.
            // The master's own clock fall after start is no bit, so
            // the count sits one below zero and that fall wraps it.
            phase <= eeprom_pkg::ph_ctrl;
            bit_cnt <= 4'hf;
            pull_low <= 1'b0;
            wbuf_valid <= 1'b0;
        end
        else if (stop_cond)
        begin
            // Stop ends any operation and frees the data line
            phase <= eeprom_pkg::ph_idle;
            bit_cnt <= 4'h0;
            pull_low <= 1'b0;
            wbuf_valid <= 1'b0;
        end
        else if (phase == eeprom_pkg::ph_idle)
        begin
            // Wait for a start, ignore everything else
            pull_low <= 1'b0;
        end
        else if (scl_rise)
        begin
            // Sample on rising clock; line is stable while high
            if (bit_cnt == eeprom_pkg::ACK_SLOT)
            begin
                // Master answer after a byte we sent
                if (phase == eeprom_pkg::ph_rdata && pb.sda_level)
                begin
                    phase <= eeprom_pkg::ph_idle;
                    bit_cnt <= 4'h0;
                    pull_low <= 1'b0;
                end
            end
            else if (phase != eeprom_pkg::ph_rdata)
                shift <= {shift[6:0], pb.sda_level};
        end
        else if (scl_fall)
        begin
            if (bit_cnt == eeprom_pkg::LAST_BIT)
            begin
                // Byte done; ninth pulse carries the acknowledge
                bit_cnt <= eeprom_pkg::ACK_SLOT;
                case (phase)
                    eeprom_pkg::ph_ctrl:
                    begin
                        // Busy memory stays silent so software polls
                        if (ctrl_match && !pb.busy)
                        begin
                            pull_low <= 1'b1;
                            read_dir <= shift[eeprom_pkg::DIR_BIT];
                        end
                        else
                        begin
                            phase <= eeprom_pkg::ph_idle;
                            pull_low <= 1'b0;
                        end
                    end
                    eeprom_pkg::ph_addr:
                    begin
                        addr_ptr <= shift[eeprom_pkg::MEM_AW-1:0];
                        pull_low <= 1'b1;
                    end
                    eeprom_pkg::ph_wdata:
                    begin
                        // Later bytes replace the buffered one
                        wbuf <= shift;
                        wbuf_valid <= 1'b1;
                        pull_low <= 1'b1;
                    end
                    eeprom_pkg::ph_rdata:
                    begin
                        // Let the master drive its acknowledge
                        pull_low <= 1'b0;
                        addr_ptr <= addr_ptr + 1'b1;
                    end
                    default:
                    begin
                        phase <= eeprom_pkg::ph_idle;
                        pull_low <= 1'b0;
                    end
                endcase
            end
            else if (bit_cnt == eeprom_pkg::ACK_SLOT)
            begin
                // Acknowledge pulse over; move to the next byte
                bit_cnt <= 4'h0;
                pull_low <= 1'b0;
                case (phase)
                    eeprom_pkg::ph_ctrl:
                    begin
                        if (read_dir)
                        begin
                            phase <= eeprom_pkg::ph_rdata;
                            shift <= rd_byte;
                            pull_low <= ~rd_byte[7];
                        end
                        else
                            phase <= eeprom_pkg::ph_addr;
                    end
                    eeprom_pkg::ph_addr:
                        phase <= eeprom_pkg::ph_wdata;
                    eeprom_pkg::ph_rdata:
                    begin
                        // Master acknowledged: stream the next byte
                        shift <= rd_byte;
                        pull_low <= ~rd_byte[7];
                    end
                    default:
                        phase <= phase;
                endcase
            end
            else
            begin
                // Mid-byte: drive the next bit while clock is low
                bit_cnt <= bit_cnt + 4'h1;
                if (phase == eeprom_pkg::ph_rdata)
                begin
                    shift <= {shift[6:0], 1'b0};
                    pull_low <= ~shift[6];
                end
            end
        end
    end

    // ==========================================================
    // Memory array; written only by a committed byte write.
    // Contents carry no reset, as a stored memory would not.
    always_ff @(posedge ref_clk)
    begin
        if (commit)
            mem[addr_ptr] <= wbuf;
    end

    // Write cycle timer; pointer stays on the written location
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            busy_cnt <= '0;
        else if (commit)
            busy_cnt <= eeprom_pkg::BUSY_W'(write_cycle_cycles);
        else if (busy_cnt != '0)
            busy_cnt <= busy_cnt - 1'b1;
    end
endmodule
`default_nettype wire

/* File: eeprom_pkg.sv */
// Constants and types shared by the on-chip serial memory block
`default_nettype none
package eeprom_pkg;
    // Clock and internal write cycle time
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned WRITE_CYCLE_MS = 4;
    localparam int unsigned WRITE_CYCLE_CYCLES = WRITE_CYCLE_MS * 1000 * CLK_MHZ;
    localparam int unsigned BUSY_W = 20;
    // Memory geometry
    localparam int unsigned MEM_DEPTH = 16;
    localparam int unsigned MEM_AW = 4;
    // Register indices and byte addresses
    localparam logic [7:0] PORT_IO_BITS_IDX = 8'h06;
    localparam logic [7:0] STATUS_IDX = 8'h07;
    localparam logic [7:0] PORT_IO_BITS_ADDR = {PORT_IO_BITS_IDX[5:0], 2'b00};
    localparam logic [7:0] STATUS_ADDR = {STATUS_IDX[5:0], 2'b00};
    // Field positions and reset values
    localparam int unsigned SDA_BIT = 6;
    localparam int unsigned SCL_BIT = 7;
    localparam int unsigned BUSY_BIT = 0;
    localparam logic SDA_RESET = 1'b1;
    localparam logic SCL_RESET = 1'b1;
    // Control byte layout
    localparam logic [3:0] DEVICE_CODE = 4'ha;
    localparam int unsigned DIR_BIT = 0;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Protocol phases of the serial slave
    typedef enum logic [2:0]
    {
        ph_idle,
        ph_ctrl,
        ph_addr,
        ph_wdata,
        ph_rdata
    } phase_t;
endpackage
`default_nettype wire

/* File: port_bits_if.sv */
// Port bits and line levels between register slave and serial core
`timescale 1ns/1ps
`default_nettype none
interface port_bits_if;
    logic sda_out;
    logic scl_out;
    logic sda_level;
    logic scl_level;
    logic busy;
    modport regs (output sda_out, output scl_out,
                  input sda_level, input scl_level, input busy);
    modport core (input sda_out, input scl_out,
                  output sda_level, output scl_level, output busy);
endinterface
`default_nettype wire

/* File: axi_port_regs.sv */
// AXI4-Lite slave holding the general port bits and a status word
`timescale 1ns/1ps
`default_nettype none
module axi_port_regs
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address and data
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Port bits toward the serial core
    port_bits_if.regs pb
);
    logic aw_full;
    logic w_full;
    logic [7:0] aw_hold;
    logic [31:0] w_hold;
    logic [3:0] s_hold;
    logic do_write;

    assign do_write = aw_full && w_full && !bvalid;

    // ==========================================================
    // Write channels, taken in either order
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            awready <= 1'b0;
            aw_full <= 1'b0;
            aw_hold <= 8'h00;
        end
        else if (awvalid && awready)
        begin
            awready <= 1'b0;
            aw_full <= 1'b1;
            aw_hold <= awaddr;
        end
        else if (do_write)
            aw_full <= 1'b0;
        else if (!aw_full)
            awready <= 1'b1;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wready <= 1'b0;
            w_full <= 1'b0;
            w_hold <= 32'h00000000;
            s_hold <= 4'h0;
        end
        else if (wvalid && wready)
        begin
            wready <= 1'b0;
            w_full <= 1'b1;
            w_hold <= wdata;
            s_hold <= wstrb;
        end
        else if (do_write)
            w_full <= 1'b0;
        else if (!w_full)
            wready <= 1'b1;
    end

    // Port bits: both lines idle high, no direction control exists
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pb.sda_out <= eeprom_pkg::SDA_RESET;
            pb.scl_out <= eeprom_pkg::SCL_RESET;
        end
        else if (do_write && s_hold[0] &&
                 aw_hold[7:2] == eeprom_pkg::PORT_IO_BITS_ADDR[7:2])
        begin
            pb.sda_out <= w_hold[eeprom_pkg::SDA_BIT];
            pb.scl_out <= w_hold[eeprom_pkg::SCL_BIT];
        end
    end

    // Response; status is read-only, writes to it are ignored
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            bvalid <= 1'b0;
            bresp <= eeprom_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid <= 1'b1;
            if (aw_hold[7:2] == eeprom_pkg::PORT_IO_BITS_ADDR[7:2] ||
                aw_hold[7:2] == eeprom_pkg::STATUS_ADDR[7:2])
                bresp <= eeprom_pkg::RESP_OKAY;
            else
                bresp <= eeprom_pkg::RESP_SLVERR;
        end
        else if (bvalid && bready)
            bvalid <= 1'b0;
    end

    // ==========================================================
    // Read channel; port bits read back the live line levels
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= eeprom_pkg::RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= 32'h00000000;
            rresp <= eeprom_pkg::RESP_OKAY;
            if (araddr[7:2] == eeprom_pkg::PORT_IO_BITS_ADDR[7:2])
            begin
                rdata[eeprom_pkg::SDA_BIT] <= pb.sda_level;
                rdata[eeprom_pkg::SCL_BIT] <= pb.scl_level;
            end
            else if (araddr[7:2] == eeprom_pkg::STATUS_ADDR[7:2])
                rdata[eeprom_pkg::BUSY_BIT] <= pb.busy;
            else
                rresp <= eeprom_pkg::RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
        else if (!rvalid)
            arready <= 1'b1;
    end
endmodule
`default_nettype wire

/* File: eeprom_monitor.sv */
// Register bus checks for the serial memory block
`timescale 1ns/1ps
`default_nettype none
module eeprom_monitor
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    // Read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready
);
    // ====================
    // Helper state
    localparam logic [5:0] PW = eeprom_pkg::PORT_IO_BITS_ADDR[7:2];
    localparam logic [5:0] SW = eeprom_pkg::STATUS_ADDR[7:2];
    logic [7:0] rd_a;
    logic [7:0] wr_a;
    logic [1:0] w_bits;
    logic w_en;
    logic scl_cmd;
    logic sda_cmd;
    logic rd_port;
    logic wr_map;
    // Address decode of the pending transfers
    assign rd_port = rd_a[7:2] == PW;
    assign wr_map = wr_a[7:2] == PW || wr_a[7:2] == SW;
    // Last commanded line bits; both high out of reset
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            {rd_a, wr_a, w_bits, w_en} <= 19'h0;
            {scl_cmd, sda_cmd} <= 2'h3;
        end
        else
        begin
            if (arvalid && arready)
                rd_a <= araddr;
            if (awvalid && awready)
                wr_a <= awaddr;
            if (wvalid && wready)
                {w_bits, w_en} <= {wdata[7:6], wstrb[0]};
            if (bvalid && bready && w_en && wr_a[7:2] == PW)
                {scl_cmd, sda_cmd} <= w_bits;
        end
    end
    // ====================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_SCL_PUSH_PULL: assert property (
        rvalid && rd_port |-> rdata[7] == scl_cmd)
        else $error("clock line differs from its port bit");
    AST_SDA_OPEN_DRAIN: assert property (
        rvalid && rd_port && !sda_cmd |-> !rdata[6])
        else $error("data line high while port bit pulls low");
    AST_PORT_SPARE: assert property (
        rvalid && rd_port |-> rdata[31:8] == 24'h0 && rdata[5:0] == 6'h0)
        else $error("spare port bits not zero");
    AST_UNMAPPED: assert property (
        rvalid && !rd_port && rd_a[7:2] != SW
        |-> rresp == eeprom_pkg::RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused");
    AST_WRITE_RESP: assert property (
        bvalid |-> bresp == (wr_map ? eeprom_pkg::RESP_OKAY
                                    : eeprom_pkg::RESP_SLVERR))
        else $error("write answer code wrong");
    AST_READ_ANSWER: assert property (
        arvalid && arready |=> rvalid)
        else $error("read answer late");
    AST_R_HOLD: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer changed before taken");
    AST_B_HOLD: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer changed before taken");
    // Main scenarios reached
    cover property (rvalid && rd_port && !rdata[6]);
    cover property (rvalid && rd_a[7:2] == SW && rdata[0]);
    cover property (bvalid && bresp == eeprom_pkg::RESP_SLVERR);
endmodule
`default_nettype wire

/* File: axil_host_model.sv */
// Register bus master standing for the processor core
`timescale 1ns/1ps
`default_nettype none
module axil_host_model
(
    // Clock
    input wire logic ref_clk,
    // Write channels
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // Read channels
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // Quiet bus from time zero
    initial
    begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = 47'h0;
        {araddr, arvalid, rready} = 10'h0;
    end
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [3:0] s, output logic [1:0] resp);
        logic done;
        @(posedge ref_clk);
        {awaddr, wdata, wstrb} <= {a, v, s};
        {awvalid, wvalid, bready} <= 3'h7;
        done = 1'b0;
        while (!done)
        begin
            @(posedge ref_clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bready && bvalid)
            begin
                resp = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
    // Read; no cycle count assumed, the bench watchdog guards hangs
    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      output logic [1:0] resp);
        logic done;
        @(posedge ref_clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        done = 1'b0;
        while (!done)
        begin
            @(posedge ref_clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rready && rvalid)
            begin
                {v, resp} = {rdata, rresp};
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
endmodule
`default_nettype wire

/* File: onchip_eeprom_two_wire_slave_tb.sv */
// Self-checking bench for the serial memory block
`timescale 1ns/1ps
`default_nettype none
module onchip_eeprom_two_wire_slave_tb;
    localparam logic [7:0] PA = eeprom_pkg::PORT_IO_BITS_ADDR;
    localparam logic [7:0] SA = eeprom_pkg::STATUS_ADDR;
    logic ref_clk, rst;
    logic [7:0] awaddr, araddr, b;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, a;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    int err_count, checked;
    // Short write cycle keeps the run brief
    onchip_eeprom_two_wire_slave #(.write_cycle_cycles(600)) dut (.*);
    axil_host_model host (.*);
    // 200 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // ====================
    // Tasks
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // One register write per line change
    task automatic lines(input logic c, input logic s);
        host.wr(PA, {24'h0, c, s, 6'h0}, 4'hf, r);
    endtask
    task automatic sbit(input logic v);
        lines(1'b0, v);
        lines(1'b1, v);
        lines(1'b0, v);
    endtask
    task automatic start();
        lines(1'b0, 1'b1);
        lines(1'b1, 1'b1);
        lines(1'b1, 1'b0);
        lines(1'b0, 1'b0);
    endtask
    task automatic stop();
        lines(1'b0, 1'b0);
        lines(1'b1, 1'b0);
        lines(1'b1, 1'b1);
    endtask
    // Byte out, then release data for the slave's answer
    task automatic sbyte(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--)
            sbit(v[i]);
        lines(1'b0, 1'b1);
        lines(1'b1, 1'b1);
        host.rd(PA, d, r);
        ack = !d[6];
        lines(1'b0, 1'b1);
    endtask
    task automatic sack(input logic [7:0] v);
        logic k;
        sbyte(v, k);
        chk("ack", 32'h1, k);
    endtask
    task automatic rbyte(input logic mack, output logic [7:0] v);
        for (int i = 7; i >= 0; i--)
        begin
            lines(1'b0, 1'b1);
            lines(1'b1, 1'b1);
            host.rd(PA, d, r);
            v[i] = d[6];
        end
        sbit(!mack);
    endtask
    // Poll the busy flag with a bounded count, retrying until free
    task automatic idle();
        int n;
        n = 0;
        do
        begin
            host.rd(SA, d, r);
            n++;
        end
        while (d[0] !== 1'b0 && n < 400);
        chk("write cycle end", 32'h0, d);
    endtask
    task automatic bwrite(input logic [7:0] ad, input logic [7:0] v);
        start();
        sack(8'ha0);
        sack(ad);
        sack(v);
        stop();
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ====================
    // Watchdog
    initial
    begin
        #200000;
        err_count++;
        results();
    end
    // Main sequence
    initial
    begin
        rst = 1'b1;
        err_count = 0;
        checked = 0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        host.rd(PA, d, r);
        chk("port reset", 32'hc0, d);
        host.rd(8'h20, d, r);
        chk("unmapped read", 32'h2, r);
        host.wr(8'h20, 32'h0, 4'hf, r);
        chk("unmapped write", 32'h2, r);
        host.wr(PA, 32'h0, 4'h0, r);
        host.rd(PA, d, r);
        chk("strobe off", 32'hc0, d);
        lines(1'b0, 1'b1);
        host.rd(PA, d, r);
        chk("clock low", 32'h40, d);
        lines(1'b1, 1'b1);
        // Wrong device code goes unanswered
        start();
        sbyte(8'h50, a);
        chk("foreign code", 32'h0, a);
        stop();
        // Byte write, then no answer while programming
        bwrite(8'hf3, 8'h5a);
        host.rd(SA, d, r);
        chk("busy", 32'h1, d);
        start();
        sbyte(8'ha0, a);
        chk("ack while busy", 32'h0, a);
        stop();
        idle();
        bwrite(8'h04, 8'hc3);
        idle();
        // Two data bytes: the last one is kept
        start();
        sack(8'ha0);
        sack(8'h05);
        sack(8'h11);
        sack(8'h22);
        stop();
        idle();
        // Address only: no write cycle starts
        start();
        sack(8'ha0);
        sack(8'h06);
        stop();
        host.rd(SA, d, r);
        chk("no busy", 32'h0, d);
        // Random read with ignored bits set, then sequential
        start();
        sack(8'ha0);
        sack(8'h03);
        start();
        sack(8'haf);
        rbyte(1'b1, b);
        chk("random read", 32'h5a, b);
        rbyte(1'b0, b);
        chk("next read", 32'hc3, b);
        host.rd(PA, d, r);
        chk("released", 32'h1, d[6]);
        stop();
        // Current address read
        start();
        sack(8'ha1);
        rbyte(1'b0, b);
        chk("current read", 32'h22, b);
        stop();
        results();
    end
endmodule
bind onchip_eeprom_two_wire_slave eeprom_monitor mon (.*);
`default_nettype wire
